// *** kpi_pkg.sv ***
// constants for the keypad and pin interrupt logic
// assumes a single 125 MHz clock and an ahb-lite master with word access
// Behaviour
// - bit set: channel waits release after clear
// - polarity bit: 0 high active, 1 low
// - twelve enables admit pins to keypad
// - keypad polarity bit shared by enabled pins
// - optional keypad interrupt on key release
// - held key repeats interrupt every N ms
// - repeat value zero disables repeat timer
// - selector codes 1..12 pick pins 0..11
// - shared debounce time, per-source debounce enables
// - write one clears request, reads zero
package kpi_pkg;

  localparam int NUM_PINS = 12;
  localparam int NUM_CH   = 5;
  localparam int NUM_SRC  = 6;

  // timing
  localparam int CLK_HZ       = 125000000;
  localparam int TICK_MS      = 1;
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_SEL0 = 32'h5000_1400;
  localparam logic [31:0] IDX_STEP = 32'h0000_0002;
  localparam logic [31:0] IDX_DEB  = 32'h5000_140c;
  localparam logic [31:0] IDX_CLR  = 32'h5000_140e;
  localparam logic [31:0] IDX_LVL  = 32'h5000_1410;
  localparam logic [31:0] IDX_KEN  = 32'h5000_1412;
  localparam logic [31:0] IDX_KCTL = 32'h5000_1414;
  localparam logic [31:0] IDX_MASK = 32'h5000_1416;
  localparam logic [31:0] IDX_STAT = 32'h5000_1418;

  // internal register select codes
  localparam logic [3:0] RS_SEL0 = 4'h0;
  localparam logic [3:0] RS_DEB  = 4'h5;
  localparam logic [3:0] RS_CLR  = 4'h6;
  localparam logic [3:0] RS_LVL  = 4'h7;
  localparam logic [3:0] RS_KEN  = 4'h8;
  localparam logic [3:0] RS_KCTL = 4'h9;
  localparam logic [3:0] RS_MASK = 4'ha;
  localparam logic [3:0] RS_STAT = 4'hb;
  localparam logic [3:0] RS_NONE = 4'hf;

  // field layout
  localparam int LVL_POL_LSB  = 0;
  localparam int LVL_WAIT_LSB = 5;
  localparam int KCTL_REP_LSB = 0;
  localparam int KCTL_POL_BIT = 6;
  localparam int KCTL_REL_BIT = 7;
  localparam int DEB_VAL_LSB  = 0;
  localparam int DEB_EN_LSB   = 6;
  localparam int SRC_KEYPAD   = 5;

  // selector codes
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST  = 4'hc;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// *** kpi_ms_tick.sv ***
// millisecond enable pulse from the system clock
// assumes hclk runs at the rate given to the divider
module kpi_ms_tick #(
  parameter int TICK_CYCLES = kpi_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // tick out
  output logic      ms_tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } kpi_tick_state_t;

  kpi_tick_state_t s_reg;
  kpi_tick_state_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == 32'(TICK_CYCLES - 1))
    begin
      s_next.cnt  = 32'h0000_0000;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign ms_tick = s_reg.tick;

endmodule

// *** kpi_debounce.sv ***
// debounce filter: a change of the raw level passes only after it has
// stood for the debounce time in ms ticks
// assumes raw is already synchronous to hclk
module kpi_debounce (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // timing
  input  wire logic       ms_tick,
  input  wire logic       enable,
  input  wire logic [5:0] debounce_time,
  // level
  input  wire logic       raw,
  output logic            filt
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       filt;
  } kpi_deb_state_t;

  kpi_deb_state_t s_reg;
  kpi_deb_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (raw == s_reg.filt)
    begin
      s_next.cnt = 6'h00;
    end
    else if (!enable || debounce_time == 6'h00)
    begin
      s_next.filt = raw;
      s_next.cnt  = 6'h00;
    end
    else if (ms_tick)
    begin
      // first tick may be partial: up to one ms short
      if (s_reg.cnt + 6'h01 >= debounce_time)
      begin
        s_next.filt = raw;
        s_next.cnt  = 6'h00;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign filt = s_reg.filt;

endmodule

// *** kpi_top.sv ***
// pin and keypad interrupt logic with ahb-lite register slave
// assumes port pins are asynchronous, one ahb master, word transfers only
//
// The AHB-Lite interface to the registers was left to the implementer.
module kpi_top #(
  parameter int TICK_CYCLES = kpi_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // port pins
  input  wire logic [11:0] port_zero_pins,
  // interrupt requests
  output logic      [4:0]  channel_irq,
  output logic             keypad_irq_request,
  output logic             irq
);

  typedef struct packed {
    logic [11:0]     sync1;
    logic [11:0]     sync2;
    logic [4:0][3:0] sel;
    logic [9:0]      lvl;
    logic [11:0]     kp_en;
    logic [7:0]      kp_ctrl;
    logic [11:0]     deb;
    logic [5:0]      mask;
    logic [5:0]      status;
    logic [4:0]      ch_req;
    logic [4:0]      ch_block;
    logic            kp_req;
    logic            kp_prev;
    logic [5:0]      rep_cnt;
    logic            ph_wr;
    logic [3:0]      ph_rs;
    logic [31:0]     rdata;
  } kpi_state_t;

  kpi_state_t s_reg;
  kpi_state_t s_next;

  logic                 ms_tick;
  logic [5:0]           src_raw;
  logic [5:0]           src_filt;

  function automatic logic [31:0] kpi_byte_addr(input logic [31:0] idx);
    kpi_byte_addr = {idx[29:0], 2'b00};
  endfunction

  function automatic logic [3:0] kpi_decode(input logic [31:0] a);
    kpi_decode = kpi_pkg::RS_NONE;
    for (int i = 0; i < kpi_pkg::NUM_CH; i++)
    begin
      if (a == kpi_byte_addr(kpi_pkg::IDX_SEL0
                             + kpi_pkg::IDX_STEP * 32'(i)))
        kpi_decode = kpi_pkg::RS_SEL0 + 4'(i);
    end
    if (a == kpi_byte_addr(kpi_pkg::IDX_DEB))
      kpi_decode = kpi_pkg::RS_DEB;
    if (a == kpi_byte_addr(kpi_pkg::IDX_CLR))
      kpi_decode = kpi_pkg::RS_CLR;
    if (a == kpi_byte_addr(kpi_pkg::IDX_LVL))
      kpi_decode = kpi_pkg::RS_LVL;
    if (a == kpi_byte_addr(kpi_pkg::IDX_KEN))
      kpi_decode = kpi_pkg::RS_KEN;
    if (a == kpi_byte_addr(kpi_pkg::IDX_KCTL))
      kpi_decode = kpi_pkg::RS_KCTL;
    if (a == kpi_byte_addr(kpi_pkg::IDX_MASK))
      kpi_decode = kpi_pkg::RS_MASK;
    if (a == kpi_byte_addr(kpi_pkg::IDX_STAT))
      kpi_decode = kpi_pkg::RS_STAT;
  endfunction

  // selected pin of a channel, zero when the code picks nothing
  function automatic logic kpi_pick(input logic [3:0]  code,
                                    input logic [11:0] pins);
    kpi_pick = 1'b0;
    if (code >= kpi_pkg::SEL_FIRST && code <= kpi_pkg::SEL_LAST)
      kpi_pick = pins[code - kpi_pkg::SEL_FIRST];
  endfunction

  kpi_ms_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ms_tick (ms_tick)
  );

  // raw active levels of the five channels and the keypad
  always_comb
  begin
    for (int i = 0; i < kpi_pkg::NUM_CH; i++)
    begin
      // an unselected channel never fires, whatever its polarity
      src_raw[i] = (s_reg.sel[i] >= kpi_pkg::SEL_FIRST)
                   && (s_reg.sel[i] <= kpi_pkg::SEL_LAST)
                   && (kpi_pick(s_reg.sel[i], s_reg.sync2)
                       ^ s_reg.lvl[kpi_pkg::LVL_POL_LSB + i]);
    end
    src_raw[kpi_pkg::SRC_KEYPAD] =
      |(s_reg.kp_en
        & (s_reg.sync2
           ^ {kpi_pkg::NUM_PINS{s_reg.kp_ctrl[kpi_pkg::KCTL_POL_BIT]}}));
  end

  generate
    for (genvar g = 0; g < kpi_pkg::NUM_SRC; g++)
    begin : g_deb
      kpi_debounce u_deb (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ms_tick       (ms_tick),
        .enable        (s_reg.deb[kpi_pkg::DEB_EN_LSB + g]),
        .debounce_time (s_reg.deb[kpi_pkg::DEB_VAL_LSB +: 6]),
        .raw           (src_raw[g]),
        .filt          (src_filt[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic        acc;
    logic        wr;
    logic [3:0]  rs;
    logic [15:0] wd;
    logic [5:0]  clr;
    logic [5:0]  set;
    logic [5:0]  rd_clr;
    logic        kp_act;
    logic        kp_fire;
    logic        rep_fire;
    logic [5:0]  rep;
    logic        wait_rel;
    logic        fire;

    acc      = 1'b0;
    wr       = 1'b0;
    rs       = kpi_pkg::RS_NONE;
    wd       = hwdata[15:0];
    clr      = 6'h00;
    set      = 6'h00;
    rd_clr   = 6'h00;
    kp_act   = src_filt[kpi_pkg::SRC_KEYPAD];
    kp_fire  = 1'b0;
    rep_fire = 1'b0;
    rep      = s_reg.kp_ctrl[kpi_pkg::KCTL_REP_LSB +: 6];
    wait_rel = 1'b0;
    fire     = 1'b0;
    s_next   = s_reg;

    // pins pass two flops before any use
    s_next.sync1 = port_zero_pins;
    s_next.sync2 = s_reg.sync1;

    // data phase of a write
    if (s_reg.ph_wr)
    begin
      unique case (s_reg.ph_rs)
        kpi_pkg::RS_DEB:  s_next.deb     = wd[11:0];
        kpi_pkg::RS_CLR:  clr            = wd[5:0];
        kpi_pkg::RS_LVL:  s_next.lvl     = wd[9:0];
        kpi_pkg::RS_KEN:  s_next.kp_en   = wd[11:0];
        kpi_pkg::RS_KCTL: s_next.kp_ctrl = wd[7:0];
        kpi_pkg::RS_MASK: s_next.mask    = wd[5:0];
        default:
        begin
          if (s_reg.ph_rs < kpi_pkg::RS_DEB)
            s_next.sel[s_reg.ph_rs[2:0]] = wd[3:0];
        end
      endcase
    end

    // address phase: data for a read is latched here so it is a flop
    acc = hsel && hready && (htrans == kpi_pkg::HTRANS_NONSEQ);
    if (acc)
    begin
      rs = kpi_decode(haddr);
      wr = hwrite;
    end
    s_next.ph_wr = acc && wr;
    s_next.ph_rs = rs;
    s_next.rdata = 32'h0000_0000;
    if (acc && !wr)
    begin
      unique case (rs)
        kpi_pkg::RS_DEB:  s_next.rdata = 32'(s_reg.deb);
        kpi_pkg::RS_LVL:  s_next.rdata = 32'(s_reg.lvl);
        kpi_pkg::RS_KEN:  s_next.rdata = 32'(s_reg.kp_en);
        kpi_pkg::RS_KCTL: s_next.rdata = 32'(s_reg.kp_ctrl);
        kpi_pkg::RS_MASK: s_next.rdata = 32'(s_reg.mask);
        kpi_pkg::RS_STAT:
        begin
          s_next.rdata = 32'(s_reg.status);
          rd_clr       = 6'h3f;
        end
        default:
        begin
          // clear register and unmapped addresses read zero
          if (rs < kpi_pkg::RS_DEB)
            s_next.rdata = 32'(s_reg.sel[rs[2:0]]);
        end
      endcase
    end

    // pin channels
    for (int i = 0; i < kpi_pkg::NUM_CH; i++)
    begin
      wait_rel = s_reg.lvl[kpi_pkg::LVL_WAIT_LSB + i];
      // a clear with wait set must not refire on the still-held key
      fire = src_filt[i] && !s_reg.ch_block[i]
             && !(clr[i] && wait_rel);
      s_next.ch_req[i] = fire || (s_reg.ch_req[i] && !clr[i]);
      if (clr[i] && wait_rel && src_filt[i])
        s_next.ch_block[i] = 1'b1;
      else if (!src_filt[i])
        s_next.ch_block[i] = 1'b0;
      set[i] = fire && !s_reg.ch_req[i];
    end

    // keypad auto-repeat, counted in ms ticks while held
    if (!kp_act || !s_reg.kp_prev || rep == 6'h00)
    begin
      s_next.rep_cnt = 6'h00;
    end
    else if (ms_tick)
    begin
      if (s_reg.rep_cnt + 6'h01 >= rep)
      begin
        s_next.rep_cnt = 6'h00;
        rep_fire       = 1'b1;
      end
      else
      begin
        s_next.rep_cnt = s_reg.rep_cnt + 6'h01;
      end
    end
    s_next.kp_prev = kp_act;
    kp_fire = (kp_act && !s_reg.kp_prev)
              || (!kp_act && s_reg.kp_prev
                  && s_reg.kp_ctrl[kpi_pkg::KCTL_REL_BIT])
              || rep_fire;
    // set wins over a clear in the same cycle
    s_next.kp_req = kp_fire
                    || (s_reg.kp_req && !clr[kpi_pkg::SRC_KEYPAD]);
    set[kpi_pkg::SRC_KEYPAD] = kp_fire;

    s_next.status = (s_reg.status & ~rd_clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg       <= '0;
      s_reg.ph_rs <= kpi_pkg::RS_NONE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // zero wait states, always okay
  assign hreadyout          = 1'b1;
  assign hresp              = kpi_pkg::HRESP_OKAY;
  assign hrdata             = s_reg.rdata;
  assign channel_irq        = s_reg.ch_req;
  assign keypad_irq_request = s_reg.kp_req;
  assign irq                = |(s_reg.status & s_reg.mask);

endmodule

// *** kpi_checker.sv ***
// assertions on kpi_top ports: bus reads and request behaviour
// assumes word writes and pins held steady around each event
module kpi_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // pins and requests
  input wire logic [11:0] port_zero_pins,
  input wire logic [4:0]  channel_irq,
  input wire logic        keypad_irq_request
);
  localparam logic [31:0] A_SEL0 = kpi_pkg::IDX_SEL0 << 2;
  localparam logic [31:0] A_CLR  = kpi_pkg::IDX_CLR << 2;
  localparam logic [31:0] A_LVL  = kpi_pkg::IDX_LVL << 2;
  localparam logic [31:0] A_KEN  = kpi_pkg::IDX_KEN << 2;
  localparam logic [31:0] A_KCTL = kpi_pkg::IDX_KCTL << 2;
  logic        dp_wr;
  logic        dp_rd;
  logic [31:0] dp_a;
  logic [3:0]  sel0;
  logic [5:0]  lvl;
  logic [11:0] ken;
  logic [1:0]  kctl;
  logic [11:0] p1, p2, p3;
  logic [4:0]  clr;
  logic        kclr;
  logic [11:0] act;
  logic        ch0_act;
  assign clr = (dp_wr && dp_a == A_CLR) ? hwdata[4:0] : 5'h00;
  assign kclr = dp_wr && dp_a == A_CLR && hwdata[5];
  // pins seen three edges late, in line with the two sync stages and the debounce flop
  assign act = kctl[0] ? ~p3 : p3;
  assign ch0_act = sel0 >= 4'h1 && sel0 <= 4'hc
                   && (p3[sel0 - 4'h1] ^ lvl[0]);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {dp_wr, dp_rd, dp_a} <= 34'h0;
      {sel0, lvl, ken, kctl} <= 24'h0;
      {p3, p2, p1} <= 36'h0;
    end
    else
    begin
      dp_wr <= hsel && hready && htrans == kpi_pkg::HTRANS_NONSEQ && hwrite;
      dp_rd <= hsel && hready && htrans == kpi_pkg::HTRANS_NONSEQ && !hwrite;
      dp_a <= haddr;
      {p3, p2, p1} <= {p2, p1, port_zero_pins};
      if (dp_wr && dp_a == A_SEL0)
        sel0 <= hwdata[3:0];
      if (dp_wr && dp_a == A_LVL)
        lvl <= hwdata[5:0];
      if (dp_wr && dp_a == A_KEN)
        ken <= hwdata[11:0];
      if (dp_wr && dp_a == A_KCTL)
        kctl <= hwdata[7:6];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence clear_held_s;
    clr[0] && ch0_act;
  endsequence

  reads_zero_a: assert property (
    dp_rd && dp_a == A_CLR |-> hrdata == 32'h0)
    else $error("clear register read not zero");
  ch_clear_only_a: assert property (
    ($past(channel_irq) & ~channel_irq & ~$past(clr)) == 5'h00)
    else $error("channel request dropped without clear");
  kp_hold_a: assert property (
    $fell(keypad_irq_request) |-> $past(kclr))
    else $error("keypad request dropped without clear");
  kp_source_a: assert property (
    $rose(keypad_irq_request) && !kctl[1] |-> (ken & act) != 12'h0)
    else $error("keypad request without enabled active pin");
  ch_sel_a: assert property (
    $rose(channel_irq[0]) |-> sel0 >= 4'h1 && sel0 <= 4'hc)
    else $error("channel fired with no input selected");
  ch_pol_a: assert property (
    $rose(channel_irq[0]) |-> ch0_act)
    else $error("channel fired on inactive level");
  wait_blocked_a: assert property (
    clear_held_s ##0 lvl[5] |=> (!channel_irq[0]) [*3])
    else $error("channel fired again before release");
  ch_refire_a: assert property (
    clear_held_s ##0 !lvl[5] |=> ##[0:3] channel_irq[0])
    else $error("channel did not fire again at once");
endmodule

bind kpi_top kpi_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .port_zero_pins(port_zero_pins),
  .channel_irq(channel_irq), .keypad_irq_request(keypad_irq_request)
);

// *** kpi_keys.sv ***
// key and switch model driving the port pins
// assumes press commands change just after a clock edge
module kpi_keys (
  // clock
  input  wire logic        hclk,
  // key commands
  input  wire logic [11:0] press,
  input  wire logic        active_low,
  input  wire logic        bounce,
  // pins
  output logic      [11:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] prev = 12'h000;
  int          shake = 0;
  initial pins = 12'h000;
  always @(posedge hclk)
  begin
    // a bouncing contact flips between old and new level before settling
    if (bounce && press != prev && shake == 0)
      shake = 7;
    if (shake > 0)
      shake = shake - 1;
    pins <= (shake[0] ? prev : press) ^ {12{active_low}};
    if (shake == 0)
      prev = press;
  end
endmodule

// *** gpio_keypad_interrupt_logic_bench.sv ***
// bench for kpi_top: bus tasks, key model, one task per scenario
// assumes a ms tick shortened to 10 cycles
module gpio_keypad_interrupt_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_SEL0 = kpi_pkg::IDX_SEL0 << 2;
  localparam logic [31:0] A_DEB  = kpi_pkg::IDX_DEB << 2;
  localparam logic [31:0] A_CLR  = kpi_pkg::IDX_CLR << 2;
  localparam logic [31:0] A_LVL  = kpi_pkg::IDX_LVL << 2;
  localparam logic [31:0] A_KEN  = kpi_pkg::IDX_KEN << 2;
  localparam logic [31:0] A_KCTL = kpi_pkg::IDX_KCTL << 2;
  localparam logic [31:0] A_MASK = kpi_pkg::IDX_MASK << 2;
  localparam logic [31:0] A_STAT = kpi_pkg::IDX_STAT << 2;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [11:0] pins;
  logic [4:0]  ch;
  logic        kp;
  logic        irq;
  logic [11:0] key = 12'h000;
  logic        al = 1'b0;
  logic        bo = 1'b0;
  int          failures = 0;
  int          checked = 0;

  always #4 hclk = ~hclk;

  kpi_top #(.TICK_CYCLES(10)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .port_zero_pins(pins), .channel_irq(ch),
    .keypad_irq_request(kp), .irq(irq)
  );
  kpi_keys u_keys (
    .hclk(hclk), .press(key), .active_low(al), .bounce(bo), .pins(pins)
  );

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [15:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= kpi_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 16'h0, r);
    chk(r, e);
    chk1(hresp, kpi_pkg::HRESP_OKAY);
  endtask

  task automatic t_regs();
    rc(A_LVL, 32'h0);
    rc(A_KEN, 32'h0);
    rc(A_KCTL, 32'h0);
    wr(A_KCTL, 16'h00c5);
    rc(A_KCTL, 32'hc5);
    wr(A_CLR, 16'h003f);
    rc(A_CLR, 32'h0);
    rc(32'h4000_5070, 32'h0);
    wr(A_KCTL, 16'h0000);
    $display("registers done");
  endtask

  task automatic t_chan();
    for (int c = 0; c < 16; c++)
    begin
      wr(A_SEL0, 16'(c));
      key <= (c >= 1 && c <= 12) ? 12'(1 << (c - 1)) : 12'hfff;
      hold(8);
      // other channels have no input selected and must stay quiet
      chk(32'(ch), 32'(c >= 1 && c <= 12));
      key <= 12'h000;
      hold(4);
      wr(A_CLR, 16'h001f);
      hold(8);
      chk1(ch[0], 1'b0);
    end
    $display("channel select done");
  endtask

  task automatic t_wait();
    al <= 1'b1;
    wr(A_LVL, 16'h0021);
    wr(A_SEL0, 16'h0001);
    hold(8);
    chk1(ch[0], 1'b0);
    key <= 12'h001;
    hold(8);
    chk1(ch[0], 1'b1);
    wr(A_CLR, 16'h0001);
    hold(8);
    chk1(ch[0], 1'b0);
    key <= 12'h000;
    hold(8);
    key <= 12'h001;
    hold(8);
    chk1(ch[0], 1'b1);
    wr(A_LVL, 16'h0001);
    wr(A_CLR, 16'h0001);
    hold(8);
    chk1(ch[0], 1'b1);
    wr(A_SEL0, 16'h0000);
    key <= 12'h000;
    al <= 1'b0;
    wr(A_LVL, 16'h0000);
    wr(A_CLR, 16'h001f);
    $display("wait release done");
  endtask

  task automatic t_keypad();
    wr(A_KEN, 16'h0008);
    key <= 12'h004;
    hold(8);
    chk1(kp, 1'b0);
    key <= 12'h008;
    hold(8);
    key <= 12'h000;
    hold(8);
    chk1(kp, 1'b1);
    wr(A_CLR, 16'h0020);
    hold(2);
    chk1(kp, 1'b0);
    wr(A_KCTL, 16'h0080);
    key <= 12'h008;
    hold(8);
    wr(A_CLR, 16'h0020);
    key <= 12'h000;
    hold(8);
    chk1(kp, 1'b1);
    wr(A_KCTL, 16'h0040);
    al <= 1'b1;
    hold(8);
    wr(A_CLR, 16'h0020);
    hold(8);
    chk1(kp, 1'b0);
    key <= 12'h008;
    hold(8);
    chk1(kp, 1'b1);
    wr(A_KEN, 16'h0000);
    key <= 12'h000;
    al <= 1'b0;
    wr(A_KCTL, 16'h0000);
    wr(A_CLR, 16'h0020);
    $display("keypad done");
  endtask

  task automatic t_repeat();
    wr(A_KEN, 16'h0001);
    wr(A_KCTL, 16'h0004);
    key <= 12'h001;
    hold(8);
    wr(A_CLR, 16'h0020);
    hold(2);
    chk1(kp, 1'b0);
    hold(40);
    chk1(kp, 1'b1);
    wr(A_KCTL, 16'h0000);
    wr(A_CLR, 16'h0020);
    // long enough to catch a zero read as the largest period
    hold(700);
    chk1(kp, 1'b0);
    key <= 12'h000;
    wr(A_KEN, 16'h0000);
    $display("repeat done");
  endtask

  task automatic t_irq();
    logic [31:0] r;
    xfer(1'b0, A_STAT, 16'h0, r);
    wr(A_KEN, 16'h0001);
    wr(A_DEB, 16'h0803);
    bo <= 1'b1;
    key <= 12'h001;
    hold(15);
    chk1(kp, 1'b0);
    hold(40);
    chk1(kp, 1'b1);
    chk1(irq, 1'b0);
    wr(A_MASK, 16'h0020);
    hold(1);
    chk1(irq, 1'b1);
    rc(A_STAT, 32'h20);
    hold(1);
    chk1(irq, 1'b0);
    // last channel on the last pin, no debounce for it
    wr(A_SEL0 + 32'h20, 16'h000c);
    key <= 12'h800;
    hold(8);
    chk(32'(ch), 32'h10);
    $display("interrupt done");
  endtask

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_chan();
    t_wait();
    t_keypad();
    t_repeat();
    t_irq();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    stop_test();
  end
endmodule
